/* File: design/fra_pkg.sv */
package fra_pkg;

  // Flag register layout
  localparam int FLAG_ZERO_BIT = 0;
  localparam int FLAG_CARRY_BIT = 1;
  localparam int FLAG_IEN_BIT = 2;
  localparam int FLAG_EXT_BIT = 3;
  localparam logic [3:0] FLAG_RESET = 4'h0;
  localparam logic [7:0] EXT_RESET = 8'h00;
  localparam logic [3:0] RESULT_RESET = 4'h0;

  // Radix limits
  localparam logic [4:0] RADIX_MIN = 5'h01;
  localparam logic [4:0] RADIX_MAX = 5'h10;

  // Operations issued by the instruction decoder
  typedef enum logic [4:0] {
    FRA_OP_NONE,
    FRA_OP_ADD,
    FRA_OP_ADC,
    FRA_OP_SUB,
    FRA_OP_SBC,
    FRA_OP_CMP,
    FRA_OP_INC,
    FRA_OP_DEC,
    FRA_OP_AND,
    FRA_OP_OR,
    FRA_OP_XOR,
    FRA_OP_BIT,
    FRA_OP_CLR,
    FRA_OP_SET,
    FRA_OP_TST,
    FRA_OP_SLL,
    FRA_OP_SRL,
    FRA_OP_RL,
    FRA_OP_RR,
    FRA_OP_ADC_RADIX,
    FRA_OP_SBC_RADIX,
    FRA_OP_INC_RADIX,
    FRA_OP_DEC_RADIX,
    FRA_OP_IDX_ADD,
    FRA_OP_SP_INCDEC
  } fra_op_t;

  // Flag register operations
  typedef enum logic [2:0] {
    FRA_FOP_NONE,
    FRA_FOP_LOAD_ACC,
    FRA_FOP_LOAD_IMM,
    FRA_FOP_AND_IMM,
    FRA_FOP_OR_IMM,
    FRA_FOP_XOR_IMM,
    FRA_FOP_POP,
    FRA_FOP_RETURN
  } fra_fop_t;

endpackage

/* File: design/fra_radix_unit.sv */
`timescale 1ns/1ps

// Add/subtract modulo a radix of 1..16, with carry/borrow relative to it
module fra_radix_unit (
  input  wire logic [3:0] opA,        // Destination digit
  input  wire logic [3:0] opB,        // Source digit
  input  wire logic       carryIn,    // Carry or borrow in
  input  wire logic       subtract,   // High for subtract
  input  wire logic [4:0] radix,      // Radix operand, 1..16
  output logic      [3:0] digit,      // Result digit
  output logic            carryOut    // Carry or borrow out
);

  logic [5:0] sum;
  logic [5:0] diff;

  // Out-of-range digits give undefined but harmless results
  always_comb begin
    sum  = {2'h0, opA} + {2'h0, opB} + {5'h00, carryIn};
    diff = {2'h0, opA} - {2'h0, opB} - {5'h00, carryIn};
    if (subtract) begin
      carryOut = diff[5];
      digit    = diff[5] ? 4'((diff + {1'h0, radix}) & 6'h0f)
                         : diff[3:0];
    end else begin
      carryOut = (sum >= {1'h0, radix});
      digit    = carryOut ? 4'(sum - {1'h0, radix}) : sum[3:0];
    end
  end

endmodule

/* File: design/fra_flag_unit.sv */
`timescale 1ns/1ps

// Flag-register software operations: mask writes and loads
module fra_flag_unit (
  input  wire logic             [3:0] flagsIn,   // Current flags
  input  wire fra_pkg::fra_fop_t      fop,       // Flag operation
  input  wire logic             [3:0] acc,       // Accumulator value
  input  wire logic             [3:0] imm,       // Four-bit immediate
  input  wire logic             [3:0] stackVal,  // Popped or saved flags
  output logic                  [3:0] flagsOut,  // Resulting flags
  output logic                        touched    // Flags written by software
);

  always_comb begin
    touched  = 1'b1;
    case (fop)
      fra_pkg::FRA_FOP_LOAD_ACC: flagsOut = acc;
      fra_pkg::FRA_FOP_LOAD_IMM: flagsOut = imm;
      fra_pkg::FRA_FOP_AND_IMM:  flagsOut = flagsIn & imm;
      fra_pkg::FRA_FOP_OR_IMM:   flagsOut = flagsIn | imm;
      fra_pkg::FRA_FOP_XOR_IMM:  flagsOut = flagsIn ^ imm;
      fra_pkg::FRA_FOP_POP:      flagsOut = stackVal;
      fra_pkg::FRA_FOP_RETURN:   flagsOut = stackVal;
      default: begin
        flagsOut = flagsIn;
        touched  = 1'b0;
      end
    endcase
  end

endmodule

/* File: design/fra_core.sv */
`timescale 1ns/1ps

// How it works
// - Carry is set on carry out of or borrow into the top bit, else cleared.
// - Add, add with carry, subtract, subtract with carry, compare, inc, dec update carry.
// - Logical operations keep carry, unless their destination is the flag register.
// - Index register adds and stack pointer inc/dec keep carry.
// - Shifts and rotates through carry update carry.
// - Carry decides jump-if-carry and jump-if-no-carry with signed displacement.
// - Maskable interrupts are accepted only while interrupt-enable is set.
// - Accepting any hardware interrupt, non-maskable too, clears interrupt-enable.
// - Non-maskable requests are accepted regardless of interrupt-enable.
// - Software interrupts run always and leave interrupt-enable alone.
// - Reset clears interrupt-enable.
// - Loading the extension register sets extension flag for the next instruction.
// - Flags copy to accumulator, load from accumulator/immediate, and mask ops.
// - Flags push, pop, and restore on return from interrupt.
// - Radix add, subtract, inc, dec produce result modulo radix 1..16.
// - Radix arithmetic sets zero from the result digit.
// - Radix arithmetic sets carry on reaching radix or borrowing below zero.
// - Zero flag follows whether arithmetic, logical or shift result is zero.
// - Extension flag clears at the end of the instruction after it was set.
module fra_core (
  input  wire logic              clk,           // Core clock
  input  wire logic              rst,           // Async reset, active high
  input  wire logic              instrValid,    // One instruction executes this cycle
  input  wire fra_pkg::fra_op_t  aluOp,         // ALU operation
  input  wire fra_pkg::fra_fop_t flagOp,        // Flag register operation
  input  wire logic        [3:0] operandDst,    // Destination operand
  input  wire logic        [3:0] operandSrc,    // Source operand
  input  wire logic        [4:0] radixOperand,  // Radix 1..16
  input  wire logic        [3:0] fourBitImm,    // Immediate for flag ops
  input  wire logic        [3:0] accIn,         // Accumulator for flag load
  input  wire logic        [3:0] stackFlagsIn,  // Flags from stack
  input  wire logic              extLoad,       // Extension register load
  input  wire logic        [7:0] extDataIn,     // Data for extension register
  input  wire logic              jumpIfCarry,   // Conditional jump on carry
  input  wire logic              jumpIfNoCarry, // Conditional jump on no carry
  input  wire logic        [7:0] signedDisp,    // Signed displacement
  input  wire logic              irqReq,        // Maskable request, from core logic
  input  wire logic              nmiReq,        // Non-maskable request pulse
  input  wire logic              swIntTake,     // Software interrupt taken
  output logic             [3:0] resultOut,     // ALU result digit
  output logic             [3:0] flagsOut,      // Flag register
  output logic             [3:0] flagsToAcc,    // Flags for copy to accumulator
  output logic             [3:0] flagsToStack,  // Flags to push or save
  output logic             [7:0] extRegOut,     // Extension register
  output logic                   extActive,     // Extension data applies now
  output logic                   interruptsEnabledState, // Interrupt-enable flag
  output logic                   branchTaken,   // Conditional jump taken
  output logic            [15:0] branchOffset,  // Displacement, extended if active
  output logic                   irqAccept,     // Maskable interrupt accepted
  output logic                   nmiAccept      // Non-maskable interrupt accepted
);

  logic [3:0] flagReg;
  logic [3:0] flagNext;
  logic [7:0] extReg;
  logic [3:0] resultReg;
  logic [3:0] resultNext;
  logic       carryNext;
  logic       carryWrite;
  logic       zeroWrite;
  logic [3:0] zeroDigit;
  logic [3:0] radixDigit;
  logic       radixCarry;
  logic       radixSub;
  logic [3:0] radixSrc;
  logic [3:0] swFlags;
  logic       swTouched;
  logic       takeInt;

  // Shared 4-bit add with carry out
  function automatic logic [4:0] add5(input logic [3:0] a, input logic [3:0] b,
                                      input logic cin);
    add5 = {1'b0, a} + {1'b0, b} + {4'h0, cin};
  endfunction

  // Shared 4-bit subtract with borrow out in bit 4
  function automatic logic [4:0] sub5(input logic [3:0] a, input logic [3:0] b,
                                      input logic bin);
    sub5 = {1'b0, a} - {1'b0, b} - {4'h0, bin};
  endfunction

  // Radix ops: increment/decrement use a source of zero with carry forced
  always_comb begin
    radixSub = (aluOp == fra_pkg::FRA_OP_SBC_RADIX) || (aluOp == fra_pkg::FRA_OP_DEC_RADIX);
    radixSrc = ((aluOp == fra_pkg::FRA_OP_INC_RADIX) ||
                (aluOp == fra_pkg::FRA_OP_DEC_RADIX)) ? 4'h0 : operandSrc;
  end

  fra_radix_unit radixUnit (
    .opA      (operandDst),
    .opB      (radixSrc),
    .carryIn  (((aluOp == fra_pkg::FRA_OP_INC_RADIX) || (aluOp == fra_pkg::FRA_OP_DEC_RADIX))
               ? 1'b1 : flagReg[fra_pkg::FLAG_CARRY_BIT]),
    .subtract (radixSub),
    .radix    (radixOperand),
    .digit    (radixDigit),
    .carryOut (radixCarry)
  );

  fra_flag_unit flagUnit (
    .flagsIn  (flagReg),
    .fop      (flagOp),
    .acc      (accIn),
    .imm      (fourBitImm),
    .stackVal (stackFlagsIn),
    .flagsOut (swFlags),
    .touched  (swTouched)
  );

  // ALU result and which flags it writes
  always_comb begin
    logic [4:0] t;
    logic       cin;
    t          = 5'h00;
    cin        = flagReg[fra_pkg::FLAG_CARRY_BIT];
    resultNext = resultReg;
    carryNext  = flagReg[fra_pkg::FLAG_CARRY_BIT];
    carryWrite = 1'b0;
    zeroWrite  = 1'b0;
    case (aluOp)
      fra_pkg::FRA_OP_ADD, fra_pkg::FRA_OP_ADC, fra_pkg::FRA_OP_INC: begin
        t = add5(operandDst, (aluOp == fra_pkg::FRA_OP_INC) ? 4'h1 : operandSrc,
                 (aluOp == fra_pkg::FRA_OP_ADC) ? cin : 1'b0);
        resultNext = t[3:0];
        carryNext  = t[4];
        carryWrite = 1'b1;
        zeroWrite  = 1'b1;
      end
      fra_pkg::FRA_OP_SUB, fra_pkg::FRA_OP_SBC, fra_pkg::FRA_OP_CMP,
      fra_pkg::FRA_OP_DEC: begin
        t = sub5(operandDst, (aluOp == fra_pkg::FRA_OP_DEC) ? 4'h1 : operandSrc,
                 (aluOp == fra_pkg::FRA_OP_SBC) ? cin : 1'b0);
        // Compare keeps the destination, only flags change
        resultNext = (aluOp == fra_pkg::FRA_OP_CMP) ? operandDst : t[3:0];
        carryNext  = t[4];
        carryWrite = 1'b1;
        zeroWrite  = 1'b1;
      end
      fra_pkg::FRA_OP_AND, fra_pkg::FRA_OP_BIT, fra_pkg::FRA_OP_TST: begin
        t          = {1'b0, operandDst & operandSrc};
        resultNext = (aluOp == fra_pkg::FRA_OP_AND) ? t[3:0] : operandDst;
        zeroWrite  = 1'b1;
      end
      fra_pkg::FRA_OP_OR, fra_pkg::FRA_OP_SET: begin
        t          = {1'b0, operandDst | operandSrc};
        resultNext = t[3:0];
        zeroWrite  = 1'b1;
      end
      fra_pkg::FRA_OP_XOR: begin
        t          = {1'b0, operandDst ^ operandSrc};
        resultNext = t[3:0];
        zeroWrite  = 1'b1;
      end
      fra_pkg::FRA_OP_CLR: begin
        t          = {1'b0, operandDst & ~operandSrc};
        resultNext = t[3:0];
        zeroWrite  = 1'b1;
      end
      fra_pkg::FRA_OP_SLL: begin
        resultNext = {operandDst[2:0], 1'b0};
        carryNext  = operandDst[3];
        carryWrite = 1'b1;
        zeroWrite  = 1'b1;
      end
      fra_pkg::FRA_OP_SRL: begin
        resultNext = {1'b0, operandDst[3:1]};
        carryNext  = operandDst[0];
        carryWrite = 1'b1;
        zeroWrite  = 1'b1;
      end
      fra_pkg::FRA_OP_RL: begin
        resultNext = {operandDst[2:0], cin};
        carryNext  = operandDst[3];
        carryWrite = 1'b1;
        zeroWrite  = 1'b1;
      end
      fra_pkg::FRA_OP_RR: begin
        resultNext = {cin, operandDst[3:1]};
        carryNext  = operandDst[0];
        carryWrite = 1'b1;
        zeroWrite  = 1'b1;
      end
      fra_pkg::FRA_OP_ADC_RADIX, fra_pkg::FRA_OP_SBC_RADIX,
      fra_pkg::FRA_OP_INC_RADIX, fra_pkg::FRA_OP_DEC_RADIX: begin
        resultNext = radixDigit;
        carryNext  = radixCarry;
        carryWrite = 1'b1;
        zeroWrite  = 1'b1;
      end
      // Address arithmetic outside this block; flags stay put
      fra_pkg::FRA_OP_IDX_ADD, fra_pkg::FRA_OP_SP_INCDEC: begin
        carryWrite = 1'b0;
        zeroWrite  = 1'b0;
      end
      default: begin
        carryWrite = 1'b0;
      end
    endcase
    // Compare and bit tests judge zero on a value they do not keep
    zeroDigit = (aluOp inside {fra_pkg::FRA_OP_CMP, fra_pkg::FRA_OP_BIT, fra_pkg::FRA_OP_TST})
                ? t[3:0] : resultNext;
  end

  // Interrupt acceptance; NMI ignores the enable flag
  always_comb begin
    nmiAccept = instrValid && nmiReq;
    irqAccept = instrValid && !nmiReq && irqReq &&
                flagReg[fra_pkg::FLAG_IEN_BIT];
    takeInt   = nmiAccept || irqAccept;
  end

  // Next flag value, in priority order
  always_comb begin
    flagNext = flagReg;
    if (instrValid) begin
      // Extension flag lives for one instruction only
      flagNext[fra_pkg::FLAG_EXT_BIT] = 1'b0;
      if (zeroWrite) begin
        flagNext[fra_pkg::FLAG_ZERO_BIT] = (zeroDigit == 4'h0);
      end
      if (carryWrite) begin
        flagNext[fra_pkg::FLAG_CARRY_BIT] = carryNext;
      end
      if (swTouched) begin
        // Flag-register destination overrides, carry included
        flagNext = swFlags;
      end
      if (extLoad) begin
        flagNext[fra_pkg::FLAG_EXT_BIT] = 1'b1;
      end
      // Software interrupts leave the enable flag alone
      if (takeInt) begin
        flagNext[fra_pkg::FLAG_IEN_BIT] = 1'b0;
      end
    end
  end

  // Flag register, layout fixed by the package
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flagReg <= fra_pkg::FLAG_RESET;
    end else begin
      flagReg <= flagNext;
    end
  end

  // Extension register holds until rewritten
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      extReg <= fra_pkg::EXT_RESET;
    end else if (instrValid && extLoad) begin
      extReg <= extDataIn;
    end
  end

  // Result register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resultReg <= fra_pkg::RESULT_RESET;
    end else if (instrValid) begin
      resultReg <= resultNext;
    end
  end

  // Branch decision; extension data widens the displacement
  always_comb begin
    branchTaken = instrValid &&
                  ((jumpIfCarry && flagReg[fra_pkg::FLAG_CARRY_BIT]) ||
                   (jumpIfNoCarry && !flagReg[fra_pkg::FLAG_CARRY_BIT]));
    branchOffset = flagReg[fra_pkg::FLAG_EXT_BIT] ? {extReg, signedDisp}
                                                  : {{8{signedDisp[7]}}, signedDisp};
  end

  // Outputs
  assign resultOut              = resultReg;
  assign flagsOut               = flagReg;
  assign flagsToAcc             = flagReg;
  assign flagsToStack           = flagReg;
  assign extRegOut              = extReg;
  assign extActive              = flagReg[fra_pkg::FLAG_EXT_BIT];
  assign interruptsEnabledState = flagReg[fra_pkg::FLAG_IEN_BIT];

  // Software interrupt needs no action here; it only keeps the enable flag
  logic swIntSeen;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      swIntSeen <= 1'b0;
    end else begin
      swIntSeen <= swIntTake;
    end
  end

endmodule

/* File: verif/fra_core_properties.sv */
`timescale 1ns/1ps

// Port-level relations of the flag and radix logic
module fra_core_properties (
  input wire logic              clk,           // Core clock
  input wire logic              rst,           // Async reset
  input wire logic              instrValid,    // Instruction strobe
  input wire fra_pkg::fra_op_t  aluOp,         // ALU op
  input wire fra_pkg::fra_fop_t flagOp,        // Flag op
  input wire logic        [3:0] operandDst,    // Destination digit
  input wire logic        [3:0] operandSrc,    // Source digit
  input wire logic        [4:0] radixOperand,  // Radix
  input wire logic        [3:0] fourBitImm,    // Immediate
  input wire logic              extLoad,       // Extension load
  input wire logic        [7:0] extDataIn,     // Extension data
  input wire logic              jumpIfCarry,   // Jump on carry
  input wire logic              jumpIfNoCarry, // Jump on no carry
  input wire logic              irqReq,        // Maskable request
  input wire logic              nmiReq,        // Non-maskable request
  input wire logic        [3:0] resultOut,     // Result digit
  input wire logic        [3:0] flagsOut,      // Flags
  input wire logic        [3:0] flagsToAcc,    // Flags to accumulator
  input wire logic        [7:0] extRegOut,     // Extension register
  input wire logic              extActive,     // Extension flag
  input wire logic              interruptsEnabledState, // Interrupt enable
  input wire logic              branchTaken,   // Jump taken
  input wire logic              irqAccept,     // Maskable accepted
  input wire logic              nmiAccept      // Non-maskable accepted
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Flag ops overwrite ALU flags, so ALU checks exclude them
  logic plain;
  assign plain = instrValid && flagOp == fra_pkg::FRA_FOP_NONE;

  carry_add_a: assert property (
    plain && aluOp == fra_pkg::FRA_OP_ADD |=> flagsOut[1] ==
    (5'($past(operandDst)) + 5'($past(operandSrc)) > 5'h0f)) else $error("carry after add");
  carry_keep_a: assert property (
    plain && (aluOp inside {[fra_pkg::FRA_OP_AND:fra_pkg::FRA_OP_TST]} ||
    aluOp >= fra_pkg::FRA_OP_IDX_ADD) |=> $stable(flagsOut[1])) else $error("carry moved");
  zero_flag_a: assert property (
    plain && aluOp inside {[fra_pkg::FRA_OP_ADD:fra_pkg::FRA_OP_SBC],
    [fra_pkg::FRA_OP_INC:fra_pkg::FRA_OP_XOR], [fra_pkg::FRA_OP_SLL:fra_pkg::FRA_OP_DEC_RADIX]}
    |=> flagsOut[0] == (resultOut == 4'h0)) else $error("zero flag wrong");
  radix_carry_a: assert property (
    plain && aluOp == fra_pkg::FRA_OP_INC_RADIX |=> flagsOut[1] ==
    (5'($past(operandDst)) + 5'h01 >= $past(radixOperand))) else $error("radix carry wrong");
  irq_mask_a: assert property (
    irqAccept |-> instrValid && irqReq && interruptsEnabledState && !nmiReq)
    else $error("irq accepted while masked");
  nmi_take_a: assert property (
    instrValid && nmiReq |-> nmiAccept) else $error("nmi not accepted");
  ien_clear_a: assert property (
    irqAccept || nmiAccept |=> !interruptsEnabledState) else $error("enable kept");
  ext_set_a: assert property (
    instrValid && extLoad |=> extActive && extRegOut == $past(extDataIn))
    else $error("extension not loaded");
  ext_life_a: assert property (
    plain && extActive && !extLoad |=> !extActive) else $error("extension outlived");
  branch_cond_a: assert property (
    instrValid && jumpIfCarry && !jumpIfNoCarry |-> branchTaken == flagsOut[1])
    else $error("jump on carry wrong");
  flag_map_a: assert property (
    extActive == flagsOut[3] && interruptsEnabledState == flagsOut[2] &&
    flagsToAcc == flagsOut) else $error("flag layout wrong");
  flag_imm_a: assert property (
    instrValid && flagOp == fra_pkg::FRA_FOP_LOAD_IMM && !extLoad && !irqAccept &&
    !nmiAccept |=> flagsOut == $past(fourBitImm)) else $error("flag load wrong");

  // Main scenarios
  cover property (irqAccept);
  cover property (nmiAccept && irqReq);
  cover property (extActive && jumpIfCarry);
endmodule

bind fra_core fra_core_properties i_props (.*);

/* File: verif/fra_decoder_model.sv */
`timescale 1ns/1ps

// Decoder side: issues one instruction at a time
module fra_decoder_model (
  input  wire logic        clk,           // Core clock
  output logic             instrValid,    // Instruction strobe
  output fra_pkg::fra_op_t aluOp,         // ALU op
  output fra_pkg::fra_fop_t flagOp,       // Flag op
  output logic       [3:0] operandDst,    // Destination digit
  output logic       [3:0] operandSrc,    // Source digit
  output logic       [4:0] radixOperand,  // Radix
  output logic       [3:0] fourBitImm,    // Immediate
  output logic       [3:0] accIn,         // Accumulator
  output logic       [3:0] stackFlagsIn,  // Stacked flags
  output logic             extLoad,       // Extension load
  output logic       [7:0] extDataIn,     // Extension data
  output logic             jumpIfCarry,   // Jump on carry
  output logic             jumpIfNoCarry, // Jump on no carry
  output logic       [7:0] signedDisp,    // Displacement
  output logic             irqReq,        // Maskable level
  output logic             nmiReq,        // Non-maskable pulse
  output logic             swIntTake      // Software interrupt
);
  // Quiet idle state at time zero
  initial begin
    {instrValid, extLoad, jumpIfCarry, jumpIfNoCarry, irqReq, nmiReq, swIntTake} = 7'h00;
    {operandDst, operandSrc, fourBitImm, accIn, stackFlagsIn} = 20'h00000;
    {extDataIn, signedDisp} = 16'h0000;
    aluOp = fra_pkg::FRA_OP_NONE;
    flagOp = fra_pkg::FRA_FOP_NONE;
    radixOperand = 5'h10;
  end

  // Fields change only at the falling edge
  task automatic issue(input fra_pkg::fra_op_t op, input fra_pkg::fra_fop_t fop,
                       input logic [3:0] d, input logic [3:0] s, input logic [4:0] r);
    @(negedge clk);
    aluOp = op;
    flagOp = fop;
    operandDst = d;
    operandSrc = s;
    radixOperand = r;
    instrValid = 1'b1;
  endtask

  // Strobe and pulses drop so nothing executes twice
  task automatic retire();
    @(posedge clk);
    @(negedge clk);
    instrValid = 1'b0;
    nmiReq = 1'b0;
    extLoad = 1'b0;
    swIntTake = 1'b0;
  endtask
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end

module tb_top;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              instrValid, extLoad, jumpIfCarry, jumpIfNoCarry, irqReq, nmiReq;
  logic              swIntTake, extActive, interruptsEnabledState, branchTaken;
  logic              irqAccept, nmiAccept;
  fra_pkg::fra_op_t  aluOp;
  fra_pkg::fra_fop_t flagOp;
  logic        [3:0] operandDst, operandSrc, fourBitImm, accIn, stackFlagsIn, resultOut;
  logic        [3:0] flagsOut, flagsToAcc, flagsToStack, expF;
  logic        [4:0] radixOperand;
  logic        [7:0] extDataIn, signedDisp, extRegOut;
  logic       [15:0] branchOffset;
  int                n_mismatch = 0;
  int                cmp_count = 0;
  logic        [3:0] dTab [4] = '{4'h9, 4'h3, 4'h0, 4'hf};
  logic        [3:0] sTab [4] = '{4'h8, 4'h4, 4'h0, 4'h1};

  fra_decoder_model i_dec (.*);
  fra_core i_dut (.*);

  // 25 MHz core clock
  always #20 clk = ~clk;

  // Returns {result known, zero known, carry, result}
  function automatic logic [6:0] refAlu(fra_pkg::fra_op_t op, logic [3:0] d, logic [3:0] s,
                                        logic c, logic [4:0] r);
    int t;
    logic [4:0] w;
    logic rk;
    w = {c, 4'h0};
    case (op)
      fra_pkg::FRA_OP_ADD: w = {1'b0, d} + s;
      fra_pkg::FRA_OP_ADC: w = {1'b0, d} + s + c;
      fra_pkg::FRA_OP_SUB, fra_pkg::FRA_OP_CMP: w = {1'b0, d} - s;
      fra_pkg::FRA_OP_SBC: w = {1'b0, d} - s - c;
      fra_pkg::FRA_OP_INC: w = {1'b0, d} + 5'h01;
      fra_pkg::FRA_OP_DEC: w = {1'b0, d} - 5'h01;
      fra_pkg::FRA_OP_AND, fra_pkg::FRA_OP_BIT, fra_pkg::FRA_OP_TST: w = {c, d & s};
      fra_pkg::FRA_OP_OR: w = {c, d | s};
      fra_pkg::FRA_OP_XOR: w = {c, d ^ s};
      fra_pkg::FRA_OP_SLL: w = {d, 1'b0};
      fra_pkg::FRA_OP_SRL: w = {d[0], 1'b0, d[3:1]};
      fra_pkg::FRA_OP_RL: w = {d, c};
      fra_pkg::FRA_OP_RR: w = {d[0], c, d[3:1]};
      fra_pkg::FRA_OP_ADC_RADIX, fra_pkg::FRA_OP_INC_RADIX: begin
        t = int'(d) + ((op == fra_pkg::FRA_OP_ADC_RADIX) ? int'(s) + int'(c) : 1);
        w = (t >= int'(r)) ? {1'b1, 4'(t - int'(r))} : {1'b0, 4'(t)};
      end
      fra_pkg::FRA_OP_SBC_RADIX, fra_pkg::FRA_OP_DEC_RADIX: begin
        t = int'(d) - ((op == fra_pkg::FRA_OP_SBC_RADIX) ? int'(s) + int'(c) : 1);
        w = (t < 0) ? {1'b1, 4'(t + int'(r))} : {1'b0, 4'(t)};
      end
      default: w = {c, 4'h0};
    endcase
    rk = op inside {[fra_pkg::FRA_OP_ADD:fra_pkg::FRA_OP_SBC],
      [fra_pkg::FRA_OP_INC:fra_pkg::FRA_OP_XOR], [fra_pkg::FRA_OP_SLL:fra_pkg::FRA_OP_DEC_RADIX]};
    return {rk, rk || op inside {fra_pkg::FRA_OP_CMP, fra_pkg::FRA_OP_BIT,
                                 fra_pkg::FRA_OP_TST}, w};
  endfunction

  // Idle instruction and its completion with a full flag compare
  task automatic nop();
    i_dec.issue(fra_pkg::FRA_OP_NONE, fra_pkg::FRA_FOP_NONE, 4'h0, 4'h0, 5'h10);
  endtask
  task automatic fin();
    i_dec.retire();
    `CHK("flags", expF, flagsOut)
  endtask

  // One ALU instruction, expectation carried in expF
  task automatic alu(fra_pkg::fra_op_t op, logic [3:0] d, logic [3:0] s, logic [4:0] r);
    logic [6:0] x;
    x = refAlu(op, d, s, expF[1], r);
    i_dec.issue(op, fra_pkg::FRA_FOP_NONE, d, s, r);
    i_dec.retire();
    expF[1] = x[4];
    `CHK("carry", expF[1], flagsOut[1])
    if (x[5]) `CHK("zero", x[3:0] == 4'h0, flagsOut[0])
    if (x[6]) `CHK("result", x[3:0], resultOut)
  endtask

  // One flag instruction; all sources carry the same value
  task automatic flg(fra_pkg::fra_fop_t fop, logic [3:0] v);
    {i_dec.fourBitImm, i_dec.accIn, i_dec.stackFlagsIn} = {v, v, v};
    i_dec.issue(fra_pkg::FRA_OP_NONE, fop, 4'h0, 4'h0, 5'h10);
    case (fop)
      fra_pkg::FRA_FOP_AND_IMM: expF = expF & v;
      fra_pkg::FRA_FOP_OR_IMM: expF = expF | v;
      fra_pkg::FRA_FOP_XOR_IMM: expF = expF ^ v;
      default: expF = v;
    endcase
    fin();
    `CHK("to acc", expF, flagsToAcc)
    `CHK("to stack", expF, flagsToStack)
  endtask

  task automatic results();
    $display("TB: %0d mismatches in %0d compares", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog far beyond the few hundred cycles of the run
  initial begin
    #200000;
    n_mismatch++;
    results();
  end

  initial begin
    expF = 4'h0;
    repeat (4) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    `CHK("reset flags", fra_pkg::FLAG_RESET, flagsOut)
    for (int o = 1; o <= 24; o++) begin
      for (int p = 0; p < 4; p++) begin
        alu(fra_pkg::fra_op_t'(o), dTab[p], sTab[p], 5'h10);
      end
    end
    alu(fra_pkg::FRA_OP_CMP, 4'h5, 4'h5, 5'h10);
    // Radix cases, including wrap at both ends and radix 1 and 16
    alu(fra_pkg::FRA_OP_ADC_RADIX, 4'h2, 4'h7, 5'h08);
    alu(fra_pkg::FRA_OP_ADC_RADIX, 4'h5, 4'h3, 5'h08);
    alu(fra_pkg::FRA_OP_SBC_RADIX, 4'h9, 4'h7, 5'h0a);
    alu(fra_pkg::FRA_OP_SBC_RADIX, 4'h1, 4'h2, 5'h0a);
    alu(fra_pkg::FRA_OP_INC_RADIX, 4'h9, 4'h0, 5'h0a);
    alu(fra_pkg::FRA_OP_DEC_RADIX, 4'h0, 4'h0, 5'h0a);
    alu(fra_pkg::FRA_OP_INC_RADIX, 4'hf, 4'h0, 5'h10);
    alu(fra_pkg::FRA_OP_ADC_RADIX, 4'h0, 4'h0, 5'h01);
    flg(fra_pkg::FRA_FOP_LOAD_IMM, 4'h6);
    flg(fra_pkg::FRA_FOP_AND_IMM, 4'hd);
    flg(fra_pkg::FRA_FOP_OR_IMM, 4'h3);
    flg(fra_pkg::FRA_FOP_XOR_IMM, 4'h5);
    flg(fra_pkg::FRA_FOP_LOAD_ACC, 4'h5);
    flg(fra_pkg::FRA_FOP_POP, 4'h6);
    flg(fra_pkg::FRA_FOP_RETURN, 4'h4);
    // Interrupt acceptance and masking
    i_dec.swIntTake = 1'b1;
    nop();
    fin();
    i_dec.irqReq = 1'b1;
    nop();
    #1 `CHK("irq accept", 1'b1, irqAccept)
    expF[2] = 1'b0;
    fin();
    nop();
    #1 `CHK("irq refused", 1'b0, irqAccept)
    fin();
    i_dec.nmiReq = 1'b1;
    nop();
    #1 `CHK("nmi masked", 1'b1, nmiAccept)
    fin();
    flg(fra_pkg::FRA_FOP_OR_IMM, 4'h4);
    i_dec.nmiReq = 1'b1;
    nop();
    #1 `CHK("nmi first", 1'b1, nmiAccept)
    `CHK("irq behind nmi", 1'b0, irqAccept)
    expF[2] = 1'b0;
    fin();
    i_dec.irqReq = 1'b0;
    // Extension lifetime and branch offsets
    flg(fra_pkg::FRA_FOP_LOAD_IMM, 4'h2);
    {i_dec.extLoad, i_dec.extDataIn} = {1'b1, 8'h64};
    nop();
    expF[3] = 1'b1;
    fin();
    `CHK("ext reg", 8'h64, extRegOut)
    {i_dec.jumpIfCarry, i_dec.signedDisp} = {1'b1, 8'h29};
    nop();
    #1 `CHK("ext offset", 16'h6429, branchOffset)
    `CHK("jump carry", 1'b1, branchTaken)
    expF[3] = 1'b0;
    fin();
    {i_dec.jumpIfCarry, i_dec.jumpIfNoCarry, i_dec.signedDisp} = {2'b01, 8'hf0};
    nop();
    #1 `CHK("offset", 16'hfff0, branchOffset)
    `CHK("jump no carry", 1'b0, branchTaken)
    fin();
    i_dec.jumpIfNoCarry = 1'b0;
    // Reset in mid-run with interrupts enabled
    flg(fra_pkg::FRA_FOP_OR_IMM, 4'h4);
    rst = 1'b1;
    @(negedge clk) `CHK("rerun flags", fra_pkg::FLAG_RESET, flagsOut)
    rst = 1'b0;
    results();
  end
endmodule
